/* ebr_pkg.sv */
`default_nettype none
package ebr_pkg;
    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam int AW = 3;
    localparam int DW = 8;
    localparam logic [AW-1:0] A_REF_CTRL = 3'h0;
    localparam logic [AW-1:0] A_REF_CMP = 3'h1;
    localparam logic [AW-1:0] A_REF_CNT = 3'h2;
    localparam logic [AW-1:0] A_BUS_CTRL = 3'h3;
    localparam logic [AW-1:0] A_DRAM_CTRL = 3'h4;
    localparam logic [AW-1:0] A_STBY_CTRL = 3'h5;
    localparam logic [AW-1:0] A_STATUS = 3'h6;
    // refresh_control_reg
    localparam int F_CLK_SEL_LO = 0;
    localparam int F_CLK_SEL_MSB = 2;
    localparam int F_CONCUR = 3;
    localparam int F_SELF_SEL = 4;
    localparam int F_SELF_STAT = 5;
    // bus_control_reg
    localparam int F_IDLE_LEN = 0;
    localparam int F_IDLE_LO = 1;
    localparam int F_IDLE_HI = 2;
    localparam int F_DW_IDLE = 3;
    localparam int F_CANCEL_OE = 4;
    localparam int F_REL_EN = 5;
    // dram_access_control_reg and standby_control_reg
    localparam int F_SDR_IDLE = 0;
    localparam int F_PORT_EN = 0;
    localparam logic [DW-1:0] RST_REF_CTRL = 8'h00;
    localparam logic [DW-1:0] RST_BUS_CTRL = 8'h06;
    localparam logic [DW-1:0] RST_DRAM_CTRL = 8'h00;
    localparam logic [DW-1:0] RST_STBY_CTRL = 8'h01;
    localparam logic [DW-1:0] RST_CMP = 8'hff;
    // ****************************************
    // Spaces, timing and states
    // ****************************************
    localparam logic [1:0] SP_NORMAL = 2'h0;
    localparam logic [1:0] SP_DRAM = 2'h1;
    localparam logic [1:0] SP_SDRAM = 2'h2;
    localparam logic [2:0] IDLE_SHORT = 3'h1;
    localparam logic [2:0] IDLE_LONG = 3'h2;
    localparam logic [2:0] REFRESH_CYCLES = 3'h4;
    localparam int PRE_W = 12;
    typedef enum logic [2:0] {
        BS_IDLE, BS_GAP, BS_ACCESS, BS_RELEASED, BS_STANDBY
    } ebr_state_t;
endpackage
`default_nettype wire

/* ebr_refresh_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ebr_refresh_timer #(
    parameter int CW = 8
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Sync reset
    input wire logic [2:0] clk_sel, // Count rate, 0 stops
    input wire logic [CW-1:0] cmp, // Compare value
    input wire logic cnt_wr, // Software write of count
    input wire logic [CW-1:0] cnt_wdata, // Count write value
    output logic [CW-1:0] count, // Current count
    output logic match // One-cycle refresh request
);
    import ebr_pkg::*;

    logic [PRE_W-1:0] pre_reg;
    logic tick;

    // Divide ratio 2, 8, 32, 128, 512, 2048 or 4096 picked by the select field
    function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
        logic [PRE_W-1:0] m;
        m = '0;
        case (sel)
            3'h1: m = 12'h001;
            3'h2: m = 12'h007;
            3'h3: m = 12'h01f;
            3'h4: m = 12'h07f;
            3'h5: m = 12'h1ff;
            3'h6: m = 12'h7ff;
            3'h7: m = 12'hfff;
            default: m = '0;
        endcase
        return m;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (srst || clk_sel == 3'h0) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    assign tick = (clk_sel != 3'h0) && ((pre_reg & div_mask(clk_sel)) == div_mask(clk_sel));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= '0;
            match <= 1'b0;
        end else begin
            match <= 1'b0;
            if (cnt_wr) begin
                count <= cnt_wdata;
            end else if (tick) begin
                if (count == cmp) begin
                    count <= '0;
                    match <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule // ebr_refresh_timer
`default_nettype wire

/* ebr_bus_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Refresh counter runs upward once its clock select is non-zero.
// - Continuous SDRAM mode: no access overlaps refresh; concurrency option ignored.
// - Standby entry with self-refresh selected issues the self-refresh command.
// - Standby exit clears self-refresh status and leaves self-refresh.
// - Pending auto-refresh completes before self-refresh entry.
// - Idle cycle insertion is enabled after reset.
// - DRAM write then normal read inserts the programmed idle cycle.
// - SDRAM read idle follows its enable in continuous SDRAM mode, then condition and length.
// - Release only in expanded mode with release enable set.
// - On request, acknowledge goes low and bus drivers turn off.
// - While released, external accesses by internal masters wait.
// - While released, refresh and standby entry wait.
// - Cancel output goes low on pending work when enabled.
// - Request high ends release and raises acknowledge.
// - Release beats a simultaneous internal external access.
// - Refresh beats a simultaneous release request.
module ebr_bus_arbiter #(
    parameter int CW = 8
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Sync reset
    input wire logic [ebr_pkg::AW-1:0] reg_addr, // Register index
    input wire logic [ebr_pkg::DW-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [ebr_pkg::DW-1:0] reg_rdata, // Read data, next cycle
    input wire logic expanded_mode, // Externally expanded mode
    input wire logic sdram_cont_mode, // Continuous SDRAM space set
    input wire logic acc_req, // Internal external-access request
    input wire logic [1:0] acc_space, // Space of requested access
    input wire logic acc_write, // Requested access is a write
    input wire logic acc_done, // Granted access finished
    input wire logic standby_req, // Standby or clock-stop entry
    input wire logic standby_exit, // Standby wake-up
    input wire logic ext_bus_request_n, // Outside bus request
    output logic ext_bus_ack_n, // Bus acknowledge
    output logic bus_drive_en, // Address, data, control drive
    output logic release_cancel_request_n, // Cancel request out
    output logic acc_grant, // Access start pulse
    output logic idle_insert, // Idle cycle in progress
    output logic refresh_cmd, // Auto-refresh start pulse
    output logic self_refresh_cmd, // Self-refresh entry pulse
    output logic self_exit_cmd, // Self-refresh exit pulse
    output logic standby_ack, // Standby entered
    output logic standby_port_en // Port output enable in standby
);
    import ebr_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [DW-1:0] ref_ctrl_reg, bus_ctrl_reg, dram_ctrl_reg, stby_ctrl_reg;
    logic [CW-1:0] cmp_reg;
    logic [CW-1:0] cnt_val;
    logic ref_match, self_stat_reg, refresh_pend_reg;
    logic [2:0] ref_busy_reg, gap_reg, gap_len;
    ebr_state_t state_reg, state_next;
    logic last_valid_reg, last_write_reg;
    logic [1:0] last_space_reg, cur_space_reg;
    logic release_ok, concur_ok, ref_start, acc_ok;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ref_ctrl_reg <= RST_REF_CTRL;
            bus_ctrl_reg <= RST_BUS_CTRL;
            dram_ctrl_reg <= RST_DRAM_CTRL;
            stby_ctrl_reg <= RST_STBY_CTRL;
            cmp_reg <= CW'(RST_CMP);
        end else if (reg_wr) begin
            if (reg_addr == A_REF_CTRL) begin
                ref_ctrl_reg <= reg_wdata;
            end else if (reg_addr == A_REF_CMP) begin
                cmp_reg <= CW'(reg_wdata);
            end else if (reg_addr == A_BUS_CTRL) begin
                bus_ctrl_reg <= reg_wdata;
            end else if (reg_addr == A_DRAM_CTRL) begin
                dram_ctrl_reg <= reg_wdata;
            end else if (reg_addr == A_STBY_CTRL) begin
                stby_ctrl_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == A_REF_CTRL) begin
                reg_rdata <= {ref_ctrl_reg[DW-1:F_SELF_STAT+1], self_stat_reg, ref_ctrl_reg[F_SELF_STAT-1:0]};
            end else if (reg_addr == A_REF_CMP) begin
                reg_rdata <= DW'(cmp_reg);
            end else if (reg_addr == A_REF_CNT) begin
                reg_rdata <= DW'(cnt_val);
            end else if (reg_addr == A_BUS_CTRL) begin
                reg_rdata <= bus_ctrl_reg;
            end else if (reg_addr == A_DRAM_CTRL) begin
                reg_rdata <= dram_ctrl_reg;
            end else if (reg_addr == A_STBY_CTRL) begin
                reg_rdata <= stby_ctrl_reg;
            end else if (reg_addr == A_STATUS) begin
                reg_rdata <= {2'h0, state_reg, (ref_busy_reg != 3'h0), refresh_pend_reg, self_stat_reg};
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    // ****************************************
    // Refresh timing
    // ****************************************
    ebr_refresh_timer #(.CW(CW)) u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_sel(ref_ctrl_reg[F_CLK_SEL_MSB:F_CLK_SEL_LO]),
        .cmp(cmp_reg),
        .cnt_wr(reg_wr && reg_addr == A_REF_CNT),
        .cnt_wdata(CW'(reg_wdata)),
        .count(cnt_val),
        .match(ref_match)
    );

    // Concurrency option only counts outside continuous SDRAM mode
    assign concur_ok = ref_ctrl_reg[F_CONCUR] && !sdram_cont_mode;
    assign release_ok = expanded_mode && bus_ctrl_reg[F_REL_EN];
    // Refresh never starts while released or in standby
    assign ref_start = refresh_pend_reg && ref_busy_reg == 3'h0
        && (state_reg == BS_IDLE
        || (state_reg == BS_ACCESS && concur_ok && cur_space_reg == SP_NORMAL));
    assign acc_ok = ref_busy_reg == 3'h0 || (concur_ok && acc_space == SP_NORMAL);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            refresh_pend_reg <= 1'b0;
        end else if (ref_match) begin // Set wins over the start-clear
            refresh_pend_reg <= 1'b1;
        end else if (ref_start) begin
            refresh_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ref_busy_reg <= '0;
            refresh_cmd <= 1'b0;
        end else begin
            refresh_cmd <= ref_start;
            if (ref_start) begin
                ref_busy_reg <= REFRESH_CYCLES;
            end else if (ref_busy_reg != 3'h0) begin
                ref_busy_reg <= ref_busy_reg - 1'b1;
            end
        end
    end

    // ****************************************
    // Idle cycle decision
    // ****************************************
    function automatic logic [2:0] idle_need(input logic lv, input logic lw, input logic [1:0] ls,
        input logic nw, input logic [1:0] ns, input logic [DW-1:0] bc, input logic sdr_en, input logic cm);
        logic [2:0] len;
        len = bc[F_IDLE_LEN] ? IDLE_LONG : IDLE_SHORT;
        if (!lv) begin
            return 3'h0;
        end else if (lw && ls == SP_DRAM && !nw && ns == SP_NORMAL) begin
            return bc[F_DW_IDLE] ? len : 3'h0;
        end else if (lw) begin
            return 3'h0;
        end else if (ls == SP_SDRAM && cm && !sdr_en) begin
            return 3'h0;
        end else if ((bc[F_IDLE_LO] && ls != ns) || (bc[F_IDLE_HI] && ls == ns)) begin
            return len;
        end
        return 3'h0;
    endfunction

    assign gap_len = idle_need(last_valid_reg, last_write_reg, last_space_reg, acc_write, acc_space,
        bus_ctrl_reg, dram_ctrl_reg[F_SDR_IDLE], sdram_cont_mode);

    // ****************************************
    // Bus state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BS_IDLE: begin
                if (refresh_pend_reg) begin
                    state_next = BS_IDLE;
                end else if (release_ok && !ext_bus_request_n && ref_busy_reg == 3'h0) begin
                    state_next = BS_RELEASED;
                end else if (standby_req && ref_busy_reg == 3'h0) begin
                    state_next = BS_STANDBY;
                end else if (acc_req && acc_ok) begin
                    state_next = (gap_len != 3'h0) ? BS_GAP : BS_ACCESS;
                end
            end
            BS_GAP: begin
                if (gap_reg == 3'h1) begin
                    state_next = BS_ACCESS;
                end
            end
            BS_ACCESS: begin
                if (acc_done) begin
                    state_next = BS_IDLE;
                end
            end
            BS_RELEASED: begin
                if (ext_bus_request_n) begin
                    state_next = BS_IDLE;
                end
            end
            BS_STANDBY: begin
                if (standby_exit) begin
                    state_next = BS_IDLE;
                end
            end
            default: state_next = BS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= BS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_reg <= '0;
        end else if (state_reg == BS_IDLE && state_next == BS_GAP) begin
            gap_reg <= gap_len;
        end else if (gap_reg != 3'h0) begin
            gap_reg <= gap_reg - 1'b1;
        end
    end

    // Access history feeds the idle decision for the next access
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_valid_reg <= 1'b0;
            last_write_reg <= 1'b0;
            last_space_reg <= SP_NORMAL;
            cur_space_reg <= SP_NORMAL;
        end else if (state_next == BS_ACCESS && state_reg != BS_ACCESS) begin
            last_valid_reg <= 1'b1;
            last_write_reg <= acc_write;
            last_space_reg <= acc_space;
            cur_space_reg <= acc_space;
        end
    end

    // ****************************************
    // Pin and command outputs
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_bus_ack_n <= 1'b1;
            bus_drive_en <= 1'b1;
            release_cancel_request_n <= 1'b1;
            acc_grant <= 1'b0;
            idle_insert <= 1'b0;
        end else begin
            ext_bus_ack_n <= state_next != BS_RELEASED;
            bus_drive_en <= state_next != BS_RELEASED;
            release_cancel_request_n <= !(state_reg == BS_RELEASED && bus_ctrl_reg[F_CANCEL_OE]
                && (acc_req || refresh_pend_reg || standby_req));
            acc_grant <= state_next == BS_ACCESS && state_reg != BS_ACCESS;
            idle_insert <= state_next == BS_GAP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            self_refresh_cmd <= 1'b0;
            self_exit_cmd <= 1'b0;
            self_stat_reg <= 1'b0;
            standby_ack <= 1'b0;
            standby_port_en <= 1'b1;
        end else begin
            // Port enable must stay set while self-refresh is in use
            standby_port_en <= stby_ctrl_reg[F_PORT_EN];
            standby_ack <= state_next == BS_STANDBY;
            self_refresh_cmd <= 1'b0;
            self_exit_cmd <= 1'b0;
            if (state_reg == BS_IDLE && state_next == BS_STANDBY && ref_ctrl_reg[F_SELF_SEL]) begin
                self_refresh_cmd <= 1'b1;
                self_stat_reg <= 1'b1;
            end else if (state_reg == BS_STANDBY && state_next == BS_IDLE) begin
                self_exit_cmd <= self_stat_reg;
                self_stat_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence rel_start_s;
        state_reg == BS_IDLE && !refresh_pend_reg && release_ok && !ext_bus_request_n && ref_busy_reg == 3'h0;
    endsequence

    release_gate_a: assert property ($fell(ext_bus_ack_n) |-> $past(release_ok))
        else $error("bus released without enable");
    release_hiz_a: assert property (!ext_bus_ack_n |-> !bus_drive_en)
        else $error("bus driven while released");
    release_prio_a: assert property (rel_start_s ##0 acc_req |=> !ext_bus_ack_n && !acc_grant)
        else $error("access beat release request");
    refresh_prio_a: assert property (state_reg == BS_IDLE && refresh_pend_reg && ref_busy_reg == 3'h0
        && !ext_bus_request_n |=> refresh_cmd && ext_bus_ack_n)
        else $error("refresh not first");
    held_off_a: assert property (!ext_bus_ack_n |-> ##1 (!acc_grant && !refresh_cmd && !self_refresh_cmd))
        else $error("work started while released");
    cancel_out_a: assert property (state_reg == BS_RELEASED && bus_ctrl_reg[F_CANCEL_OE]
        && refresh_pend_reg |=> !release_cancel_request_n)
        else $error("cancel request missing");
    release_end_a: assert property (state_reg == BS_RELEASED && ext_bus_request_n |=> ext_bus_ack_n)
        else $error("acknowledge not raised");
    no_overlap_a: assert property (ref_busy_reg != 3'h0 && sdram_cont_mode |-> ##1 !acc_grant)
        else $error("access overlapped refresh");
    self_entry_a: assert property ($rose(standby_ack) && ref_ctrl_reg[F_SELF_SEL]
        |-> self_refresh_cmd && $past(ref_busy_reg == 3'h0))
        else $error("self-refresh entry wrong");
    self_exit_a: assert property (state_reg == BS_STANDBY && standby_exit && self_stat_reg
        |=> self_exit_cmd && !self_stat_reg && !standby_ack)
        else $error("self-refresh exit wrong");
    idle_default_a: assert property ($past(srst) |-> bus_ctrl_reg[F_IDLE_LO])
        else $error("idle insertion off after reset");
    dw_idle_a: assert property (state_reg == BS_IDLE && state_next == BS_ACCESS && last_valid_reg && last_write_reg
        && last_space_reg == SP_DRAM && !acc_write && acc_space == SP_NORMAL |-> !bus_ctrl_reg[F_DW_IDLE])
        else $error("idle missing after DRAM write");
endmodule // ebr_bus_arbiter
`default_nettype wire

/* ebr_ext_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Outside bus master
// ****************************************
module ebr_ext_master_model #(
    parameter int HOLD = 24
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Sync reset
    input wire logic go, // Start one bus request
    input wire logic ext_bus_ack_n, // Acknowledge from the device
    output logic ext_bus_request_n // Bus request to the device
);
    int cnt;
    // Holds the request for a fixed span after the grant, cancel or not
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_bus_request_n <= 1'b1;
            cnt <= 0;
        end else if (go) begin
            ext_bus_request_n <= 1'b0;
        end else if (!ext_bus_request_n && !ext_bus_ack_n) begin
            if (cnt == HOLD - 1) begin
                ext_bus_request_n <= 1'b1;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // ebr_ext_master_model
`default_nettype wire

/* ext_bus_release_refresh_arb_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_release_refresh_arb_test;
    import ebr_pkg::*;
    logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, expanded_mode = 0, sdram_cont_mode = 0, go = 0;
    logic acc_req = 0, acc_write = 0, acc_done = 0, standby_req = 0, standby_exit = 0, rd_seen = 0;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0, reg_rdata, cmp_val;
    logic [1:0] acc_space = SP_NORMAL;
    logic ext_bus_request_n, ext_bus_ack_n, bus_drive_en, release_cancel_request_n, acc_grant, idle_insert;
    logic refresh_cmd, self_refresh_cmd, self_exit_cmd, standby_ack, standby_port_en;
    logic [DW-1:0] exp_q[$];
    int fail_count = 0, n_tests = 0, n_ref = 0, i, ref_base;
    // ****************************************
    // Design and far side
    // ****************************************
    ebr_bus_arbiter #(.CW(8)) dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .expanded_mode(expanded_mode), .sdram_cont_mode(sdram_cont_mode), .acc_req(acc_req),
        .acc_space(acc_space), .acc_write(acc_write), .acc_done(acc_done), .standby_req(standby_req),
        .standby_exit(standby_exit), .ext_bus_request_n(ext_bus_request_n), .ext_bus_ack_n(ext_bus_ack_n),
        .bus_drive_en(bus_drive_en), .release_cancel_request_n(release_cancel_request_n),
        .acc_grant(acc_grant), .idle_insert(idle_insert), .refresh_cmd(refresh_cmd),
        .self_refresh_cmd(self_refresh_cmd), .self_exit_cmd(self_exit_cmd), .standby_ack(standby_ack),
        .standby_port_en(standby_port_en));
    ebr_ext_master_model #(.HOLD(24)) master (.ref_clk(ref_clk), .srst(srst), .go(go),
        .ext_bus_ack_n(ext_bus_ack_n), .ext_bus_request_n(ext_bus_request_n));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic results;
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    // Counts idle cycles up to the grant; a negative expectation skips the count check
    task automatic acc(input logic [1:0] sp, input logic w, input int exp_idle);
        int n;
        int k;
        n = 0;
        @(posedge ref_clk);
        acc_req <= 1'b1;
        acc_space <= sp;
        acc_write <= w;
        for (k = 0; k < 12 && acc_grant !== 1'b1; k++) begin
            @(negedge ref_clk);
            if (idle_insert === 1'b1) n++;
        end
        chk("acc_grant", 8'h01, {7'h0, acc_grant});
        if (exp_idle >= 0) chk("idle_cycles", exp_idle[7:0], n[7:0]);
        @(posedge ref_clk);
        acc_req <= 1'b0;
        acc_done <= 1'b1;
        @(posedge ref_clk);
        acc_done <= 1'b0;
    endtask
    // ****************************************
    // Read-data monitor
    // ****************************************
    always @(posedge ref_clk) begin
        if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
        if (refresh_cmd === 1'b1) n_ref++;
    end
    initial begin
        #400000;
        fail_count++;
        results();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(20));
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rd(A_REF_CTRL, RST_REF_CTRL);
        rd(A_REF_CMP, RST_CMP);
        rd(A_BUS_CTRL, RST_BUS_CTRL);
        rd(A_DRAM_CTRL, RST_DRAM_CTRL);
        rd(A_STBY_CTRL, RST_STBY_CTRL);
        rd(A_STATUS, 8'h00);
        rd(3'h7, 8'h00);
        cmp_val = 8'($urandom_range(6, 2));
        wr(A_REF_CNT, 8'h00);
        wr(A_REF_CMP, cmp_val);
        rd(A_REF_CMP, cmp_val);
        repeat (20) @(posedge ref_clk);
        chk("refresh_stopped", 8'h00, 8'(n_ref));
        wr(A_REF_CTRL, 8'h01);
        for (i = 0; i < 60 && n_ref == 0; i++) @(negedge ref_clk);
        chk("refresh_cmd", 8'h01, 8'(n_ref));
        wr(A_REF_CTRL, 8'h00);
        expanded_mode <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("ack_disabled", 8'h01, {7'h0, ext_bus_ack_n});
        wr(A_BUS_CTRL, 8'h36);
        for (i = 0; i < 10 && ext_bus_ack_n !== 1'b0; i++) @(negedge ref_clk);
        chk("ext_bus_ack_n", 8'h00, {7'h0, ext_bus_ack_n});
        chk("bus_drive_en", 8'h00, {7'h0, bus_drive_en});
        @(posedge ref_clk);
        acc_req <= 1'b1;
        acc_space <= SP_NORMAL;
        acc_write <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("grant_held", 8'h00, {7'h0, acc_grant});
        chk("cancel_n", 8'h00, {7'h0, release_cancel_request_n});
        for (i = 0; i < 40 && ext_bus_ack_n !== 1'b1; i++) @(negedge ref_clk);
        chk("ack_end", 8'h01, {7'h0, ext_bus_ack_n});
        acc(SP_NORMAL, 1'b0, -1);
        wr(A_BUS_CTRL, 8'h09);
        acc(SP_DRAM, 1'b1, -1);
        acc(SP_NORMAL, 1'b0, 2);
        wr(A_BUS_CTRL, 8'h06);
        sdram_cont_mode <= 1'b1;
        acc(SP_SDRAM, 1'b0, -1);
        acc(SP_NORMAL, 1'b0, 0);
        wr(A_DRAM_CTRL, 8'h01);
        acc(SP_SDRAM, 1'b0, -1);
        acc(SP_NORMAL, 1'b0, 1);
        sdram_cont_mode <= 1'b0;
        // Self-refresh entry and exit; port enable checked still set after exit
        wr(A_REF_CTRL, 8'h10);
        @(posedge ref_clk);
        standby_req <= 1'b1;
        for (i = 0; i < 10 && self_refresh_cmd !== 1'b1; i++) @(negedge ref_clk);
        chk("self_refresh_cmd", 8'h01, {7'h0, self_refresh_cmd});
        chk("standby_ack", 8'h01, {7'h0, standby_ack});
        rd(A_REF_CTRL, 8'h30);
        @(posedge ref_clk);
        standby_exit <= 1'b1;
        standby_req <= 1'b0;
        @(posedge ref_clk);
        standby_exit <= 1'b0;
        for (i = 0; i < 10 && self_exit_cmd !== 1'b1; i++) @(negedge ref_clk);
        chk("self_exit_cmd", 8'h01, {7'h0, self_exit_cmd});
        rd(A_REF_CTRL, 8'h10);
        chk("standby_port_en", 8'h01, {7'h0, standby_port_en});
        // Refresh pending at standby entry runs before self-refresh
        wr(A_BUS_CTRL, 8'h36);
        wr(A_REF_CNT, cmp_val);
        wr(A_REF_CTRL, 8'h11);
        repeat (3) @(posedge ref_clk);
        ref_base = n_ref;
        standby_req <= 1'b1;
        for (i = 0; i < 20 && self_refresh_cmd !== 1'b1; i++) @(negedge ref_clk);
        chk("refresh_first", 8'h01, 8'(n_ref - ref_base));
        // Refresh and release pile up in standby; refresh goes first on wake-up
        repeat (16) @(posedge ref_clk);
        go <= 1'b1;
        wr(A_REF_CTRL, 8'h10);
        go <= 1'b0;
        ref_base = n_ref;
        standby_exit <= 1'b1;
        standby_req <= 1'b0;
        @(posedge ref_clk);
        standby_exit <= 1'b0;
        for (i = 0; i < 20 && ext_bus_ack_n !== 1'b0; i++) @(negedge ref_clk);
        chk("refresh_before_release", 8'h01, 8'(n_ref - ref_base));
        chk("ack_after_refresh", 8'h00, {7'h0, ext_bus_ack_n});
        // A refresh request during release waits and asks for the bus back
        wr(A_REF_CNT, cmp_val);
        wr(A_REF_CTRL, 8'h01);
        wr(A_REF_CTRL, 8'h00);
        repeat (4) @(negedge ref_clk);
        chk("cancel_on_refresh", 8'h00, {7'h0, release_cancel_request_n});
        chk("refresh_held", 8'h01, 8'(n_ref - ref_base));
        for (i = 0; i < 40 && ext_bus_ack_n !== 1'b1; i++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk("refresh_after_release", 8'h02, 8'(n_ref - ref_base));
        repeat (4) @(posedge ref_clk);
        results();
    end
endmodule // ext_bus_release_refresh_arb_test
`default_nettype wire
